// ==== asr_params.svh ====
// Timing constants and pin widths for the asynchronous SRAM host controller
`ifndef ASR_PARAMS_SVH
`define ASR_PARAMS_SVH

`define ASR_ADDR_W 18
`define ASR_DATA_W 4
`define ASR_CLK_MHZ 25
`define ASR_CLK_PERIOD_NS 40
// Slower grade figures, in ns
`define ASR_READ_CYCLE_MIN_NS 10
`define ASR_ACCESS_MAX_NS 10
`define ASR_WRITE_PULSE_MIN_NS 7
`define ASR_WRITE_PULSE_OE_LOW_NS 10
`define ASR_WRITE_DATA_SETUP_NS 5
`define ASR_DESELECT_FLOAT_DELAY_NS 5
`define ASR_WRITE_CYCLE_MIN_NS 10
// Stages between a data pin and the captured read word
`define ASR_SYNC_CYC 3
// Cycles: minimums round up
`define ASR_CYC_UP(ns) (((ns) + `ASR_CLK_PERIOD_NS - 1) / `ASR_CLK_PERIOD_NS)
// Read phase covers access time plus the pin synchroniser
`define ASR_READ_CYC (`ASR_CYC_UP(`ASR_ACCESS_MAX_NS + `ASR_CLK_PERIOD_NS) + `ASR_SYNC_CYC)
`define ASR_WRITE_CYC `ASR_CYC_UP(`ASR_WRITE_PULSE_OE_LOW_NS)
`define ASR_FLOAT_CYC `ASR_CYC_UP(`ASR_DESELECT_FLOAT_DELAY_NS)

`endif

// ==== asr_pkg.sv ====
// Types for the asynchronous SRAM host controller
`default_nettype none
package asr_pkg;
  typedef enum logic [1:0] {
    ASR_IDLE,
    ASR_READ,
    ASR_WRITE,
    ASR_FLOAT
  } asr_state_e;
endpackage : asr_pkg
`default_nettype wire

// ==== asr_tmr_if.sv ====
// Interface between sequencer and phase timer
`timescale 1ns/1ns
`default_nettype none
interface asr_tmr_if;
  logic load;
  logic [3:0] count;
  logic done;
  modport seq (output load, output count, input done);
  modport tmr (input load, input count, output done);
endinterface : asr_tmr_if
`default_nettype wire

// ==== asr_phase_timer.sv ====
// Phase timer that counts cycles for each pin phase
`timescale 1ns/1ns
`default_nettype none
module asr_phase_timer (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Sequencer side
  asr_tmr_if.tmr t
);
  logic [3:0] cnt_q;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cnt_q <= 4'h0;
    end else if (t.load) begin
      cnt_q <= t.count;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end
  end

  // Count alone decides done, so load and done form no loop
  assign t.done = (cnt_q == 4'h0);
endmodule : asr_phase_timer
`default_nettype wire

// ==== asr_ctrl.sv ====
// Host controller that drives a 256K x 4 asynchronous SRAM
`include "asr_params.svh"
`timescale 1ns/1ns
`default_nettype none
module asr_ctrl (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // User request
  input wire logic REQ_VALID,
  output logic REQ_READY,
  input wire logic REQ_WRITE,
  input wire logic [`ASR_ADDR_W-1:0] REQ_ADDR,
  input wire logic [`ASR_DATA_W-1:0] REQ_WDATA,
  // User answer
  output logic RSP_VALID,
  output logic [`ASR_DATA_W-1:0] RSP_RDATA,
  // Memory pins
  output logic [`ASR_ADDR_W-1:0] ADDRESS_LINES,
  output logic CS_N,
  output logic WE_N,
  output logic OE_N,
  input wire logic [`ASR_DATA_W-1:0] SHARED_DATA_PINS_I,
  output logic [`ASR_DATA_W-1:0] SHARED_DATA_PINS_O,
  output logic SHARED_DATA_PINS_OE
);
  asr_pkg::asr_state_e state_q;
  wire logic [`ASR_DATA_W-1:0] rd_sync;
  logic take;

  asr_tmr_if tmr ();

  asr_phase_timer u_timer (
    .CLK(CLK),
    .RST_N(RST_N),
    .t(tmr.tmr)
  );

  // ==========================================
  // Request acceptance
  // Spacing by float phase
  assign REQ_READY = (state_q == asr_pkg::ASR_IDLE);
  assign take = REQ_VALID && REQ_READY;

  always_comb begin
    tmr.load = 1'b0;
    tmr.count = 4'h0;
    if (take) begin
      tmr.load = 1'b1;
      tmr.count = REQ_WRITE ? 4'(`ASR_WRITE_CYC) : 4'(`ASR_READ_CYC);
    end else if ((state_q == asr_pkg::ASR_READ || state_q == asr_pkg::ASR_WRITE) && tmr.done) begin
      tmr.load = 1'b1;
      tmr.count = 4'(`ASR_FLOAT_CYC);
    end
  end

  // ==========================================
  // Sequencer
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_q <= asr_pkg::ASR_IDLE;
    end else begin
      unique case (state_q)
        asr_pkg::ASR_IDLE: begin
          if (take) begin
            state_q <= REQ_WRITE ? asr_pkg::ASR_WRITE : asr_pkg::ASR_READ;
          end
        end
        asr_pkg::ASR_READ, asr_pkg::ASR_WRITE: begin
          if (tmr.done) begin
            state_q <= asr_pkg::ASR_FLOAT;
          end
        end
        asr_pkg::ASR_FLOAT: begin
          if (tmr.done) begin
            state_q <= asr_pkg::ASR_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================
  // Address and write data
  // Address held from request to idle
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ADDRESS_LINES <= '0;
    end else if (take) begin
      ADDRESS_LINES <= REQ_ADDR;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      SHARED_DATA_PINS_O <= 4'h0;
    end else if (take) begin
      SHARED_DATA_PINS_O <= REQ_WDATA;
    end
  end

  // ==========================================
  // Strobes
  // Strobes fall one edge after address
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      CS_N <= 1'b1;
    end else begin
      CS_N <= !(state_q == asr_pkg::ASR_READ || state_q == asr_pkg::ASR_WRITE)
              || tmr.done;
    end
  end

  // Write ends on write enable rise
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      WE_N <= 1'b1;
    end else begin
      WE_N <= !(state_q == asr_pkg::ASR_WRITE) || tmr.done;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      OE_N <= 1'b1;
    end else begin
      OE_N <= !(state_q == asr_pkg::ASR_READ) || tmr.done;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      SHARED_DATA_PINS_OE <= 1'b0;
    end else begin
      SHARED_DATA_PINS_OE <= (state_q == asr_pkg::ASR_WRITE) && !tmr.done;
    end
  end

  // ==========================================
  // Read capture
  // Three stages per data pin
  for (genvar b = 0; b < `ASR_DATA_W; b = b + 1) begin : g_sync
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic hold_q;

    always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
        s1_q <= 1'b0;
        s2_q <= 1'b0;
        s3_q <= 1'b0;
      end else begin
        s1_q <= SHARED_DATA_PINS_I[b];
        s2_q <= s1_q;
        s3_q <= s2_q;
      end
    end

    // Change counts once stages two and three agree
    always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
        hold_q <= 1'b0;
      end else if (s2_q == s3_q) begin
        hold_q <= s3_q;
      end
    end

    assign rd_sync[b] = hold_q;
  end

  // ==========================================
  // Read answer
  // Sample after access and sync time
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      RSP_VALID <= 1'b0;
    end else begin
      RSP_VALID <= (state_q == asr_pkg::ASR_READ) && tmr.done;
    end
  end

  // Word held until the next read ends
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      RSP_RDATA <= 4'h0;
    end else if (state_q == asr_pkg::ASR_READ && tmr.done) begin
      RSP_RDATA <= rd_sync;
    end
  end
endmodule : asr_ctrl
`default_nettype wire

// ==== asr_ctrl_monitor.sv ====
// Pin checker for the SRAM host controller
`include "asr_params.svh"
`timescale 1ns/1ns
`default_nettype none
module asr_ctrl_monitor (
  // Watched ports
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic REQ_VALID,
  input wire logic REQ_READY,
  input wire logic REQ_WRITE,
  input wire logic RSP_VALID,
  input wire logic [`ASR_ADDR_W-1:0] ADDRESS_LINES,
  input wire logic CS_N,
  input wire logic WE_N,
  input wire logic OE_N,
  input wire logic [`ASR_DATA_W-1:0] SHARED_DATA_PINS_O,
  input wire logic SHARED_DATA_PINS_OE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  a_read_we_high: assert property (!OE_N |-> WE_N && !SHARED_DATA_PINS_OE)
    else $error("read strobe overlaps write or host drive");
  a_addr_stable: assert property (!CS_N |-> $stable(ADDRESS_LINES))
    else $error("address moved while selected");
  a_wdata_stable: assert property (!WE_N |-> SHARED_DATA_PINS_OE && $stable(SHARED_DATA_PINS_O))
    else $error("write data not held");
  a_write_pulse: assert property ($fell(WE_N) |-> !CS_N ##1 WE_N && CS_N)
    else $error("write pulse shape");
  a_rsp_latency: assert property (REQ_VALID && REQ_READY && !REQ_WRITE |-> ##7 RSP_VALID)
    else $error("read answer late");
  a_busy_read: assert property (REQ_VALID && REQ_READY && !REQ_WRITE |=> !REQ_READY [*8])
    else $error("read spacing");
  a_busy_write: assert property (REQ_VALID && REQ_READY && REQ_WRITE |=> !REQ_READY [*4])
    else $error("write spacing");
  a_float_gap: assert property ($rose(CS_N) |=> CS_N)
    else $error("no float gap");
endmodule : asr_ctrl_monitor
bind asr_ctrl asr_ctrl_monitor mon (.CLK(CLK), .RST_N(RST_N), .REQ_VALID(REQ_VALID),
  .REQ_READY(REQ_READY), .REQ_WRITE(REQ_WRITE), .RSP_VALID(RSP_VALID),
  .ADDRESS_LINES(ADDRESS_LINES), .CS_N(CS_N), .WE_N(WE_N), .OE_N(OE_N),
  .SHARED_DATA_PINS_O(SHARED_DATA_PINS_O), .SHARED_DATA_PINS_OE(SHARED_DATA_PINS_OE));
`default_nettype wire

// ==== asr_sram_model.sv ====
// Behavioural 256K x 4 asynchronous SRAM
`timescale 1ns/1ns
`default_nettype none
module asr_sram_model (
  // Memory pins
  input wire logic [17:0] a,
  input wire logic cs_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic [3:0] d_in,
  output logic [3:0] d_out
);
  logic [3:0] mem [0:262143];
  logic [3:0] last;
  logic drv;
  assign drv = !cs_n && we_n && !oe_n;
  always @(cs_n, we_n, a, d_in) if (!cs_n && !we_n) mem[a] = d_in;
  always @* if (drv) last = mem[a];
  assign #6 d_out = drv ? last : ~last;
endmodule : asr_sram_model
`default_nettype wire

// ==== test_asr_ctrl.sv ====
// Random testbench for the SRAM host controller
`include "asr_params.svh"
`timescale 1ns/1ns
`default_nettype none
module test_asr_ctrl;
  logic CLK = 1'h0, RST_N = 1'h0, v = 1'h0, wr = 1'h0;
  logic [17:0] ad = 18'h0, al, la;
  logic [3:0] wd = 4'h0, rd, po, dm;
  logic rdy, rv, cs, we, oe, poe;
  wire logic [3:0] pi;
  logic [3:0] ref_m [logic [17:0]];
  logic [17:0] q[$];
  int fails = 0, n_checks = 0, s;
  assign pi = poe ? po : dm;
  always #20 CLK = ~CLK;
  asr_ctrl dut (.CLK(CLK), .RST_N(RST_N), .REQ_VALID(v), .REQ_READY(rdy), .REQ_WRITE(wr),
    .REQ_ADDR(ad), .REQ_WDATA(wd), .RSP_VALID(rv), .RSP_RDATA(rd), .ADDRESS_LINES(al),
    .CS_N(cs), .WE_N(we), .OE_N(oe), .SHARED_DATA_PINS_I(pi), .SHARED_DATA_PINS_O(po),
    .SHARED_DATA_PINS_OE(poe));
  asr_sram_model dev (.a(al), .cs_n(cs), .we_n(we), .oe_n(oe), .d_in(pi), .d_out(dm));
  task wrap_up;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up
  task chk(input bit ok, input string m);
    n_checks++;
    if (!ok) begin
      fails++;
      $display("mismatch %0t %s", $time, m);
    end
  endtask : chk
  task acc(input logic w, input logic [17:0] a, input logic [3:0] d);
    int k;
    @(negedge CLK);
    v = 1'h1; wr = w; ad = a; wd = d;
    k = 0;
    while (rdy !== 1'b1 && k < 20) begin
      @(negedge CLK);
      k++;
    end
    @(negedge CLK);
    v = 1'h0;
    if (k == 20) begin
      chk(0, "ready hang");
      wrap_up;
    end
    if (w) ref_m[a] = d;
    else begin
      k = 1;
      while (rv !== 1'b1 && k < 12) begin
        @(negedge CLK);
        k++;
      end
      if (rv !== 1'b1) begin
        chk(0, "answer hang");
        wrap_up;
      end
      chk(k == `ASR_READ_CYC + 2, "read latency");
      chk(rd === ref_m[a], "read data");
    end
  endtask : acc
  initial begin
    s = $urandom(32'h48a36f99);
    repeat (5) @(negedge CLK);
    RST_N = 1'h1;
    chk(cs === 1'b1 && we === 1'b1 && poe === 1'b0, "idle pins");
    acc(1'h1, 18'h0, 4'ha);
    acc(1'h1, 18'h3ffff, 4'h5);
    acc(1'h0, 18'h0, 4'h0);
    acc(1'h0, 18'h3ffff, 4'h0);
    repeat (40) begin
      la = 18'($urandom);
      acc(1'h1, la, 4'($urandom));
      q.push_back(la);
      acc(1'h0, q[$urandom % q.size()], 4'h0);
    end
    wrap_up;
  end
endmodule : test_asr_ctrl
`default_nettype wire
